// ### rtl/smpc_pkg.sv
package smpc_pkg;
    // ****************************************
    // Geometry and timing
    // ****************************************
    localparam int ROWS = 8;
    localparam int COLS = 12;
    localparam int XP_W = 96;
    localparam int PORT_W = 16;
    localparam int CLK_NS = 40;
    localparam int TRIG_MIN_NS = 600;
    localparam int COL_IN_LO = 0;
    localparam int COL_IN_HI = 1;
    localparam int COL_OUT_LO = 10;
    localparam int COL_OUT_HI = 11;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_DOUT = 8'h0c;
    localparam logic [7:0] REG_DIN = 8'h10;
    localparam logic [7:0] REG_ERR = 8'h14;
    localparam logic [7:0] REG_SETTLE = 8'h18;
    localparam logic [7:0] REG_STEP = 8'h1c;
    localparam logic [2:0] DISP_ROWS_HI = 3'h2;
    localparam logic [2:0] RELAY_ROWS_HI = 3'h3;
    localparam int CTRL_COPY = 0;
    localparam int CTRL_TRIG_EN = 1;
    localparam int CTRL_EXT_SRC = 2;
    localparam int CTRL_EDGE_RISE = 3;
    localparam int CTRL_RDY_HIGH = 4;
    localparam int CTRL_LOCKOUT = 5;
    localparam int CTRL_TALK = 6;
    localparam int CTRL_LISTEN = 7;
    localparam logic [7:0] CTRL_RST = 8'h18;
    localparam int CMD_SEND = 0;
    localparam int CMD_STORE = 1;
    localparam int CMD_OPEN = 2;
    localparam int CMD_RESET = 3;
    localparam int CMD_REMOTE = 4;
    localparam int ERR_OVERRUN = 0;
    localparam logic [6:0] FACTORY_ADDR = 7'h12;
    localparam logic [6:0] SLAVE_MAX = 7'h1e;
    localparam logic [6:0] MASTER_MIN = 7'h1f;
    localparam logic [6:0] MASTER_MAX = 7'h3c;
    localparam logic [6:0] MASTER_BIAS = 7'h1e;
    typedef enum logic {VIEW_XP, VIEW_PORT} smpc_view_t;
endpackage : smpc_pkg

// ### rtl/smpc_mem.sv
`timescale 1ns/100ps
module smpc_mem #(
    parameter int WIDTH = 96, // Bits per setup
    parameter int DEPTH = 16 // Setups held
) (
    input wire logic sys_clk, // System clock
    input wire logic we, // Write strobe
    input wire logic [$clog2(DEPTH)-1:0] waddr, // Write index
    input wire logic [WIDTH-1:0] wdata, // Write setup
    input wire logic [$clog2(DEPTH)-1:0] raddr, // Read index
    output logic [WIDTH-1:0] rdata_ff // Registered read setup
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_ff <= mem[raddr];
    end
endmodule : smpc_mem

// ### rtl/smpc_panel.sv
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
// Operation
// - Copy on: display edits reach relays immediately
// - Copy key toggles copy mode and lamp
// - Display starts in crosspoint view
// - Crosspoint view lights the display setup, 8x12
// - Bus and pen edit; store or send
// - Inputs shown in columns 1-2, live
// - Outputs shown in columns 11-12
// - Pen on output lamp toggles output
// - Local key: remote to local, view toggle
// - Panel honoured in local unless lockout
// - Reset key: open relays, steps 000/001
// - Open key clears lamps in crosspoint view only; relays via copy
// - Outside edge advances setup when enabled
// - Ready drops on switching, returns after settling
// - Any error bit lights lamp, poll flag
// - Talk, receiver, bus-control lamps show state
// - Switches 0-30 slave/alone, 31-60 master
// - Switch address defaults to 18
// - One pen serves eight chained units
module smpc_panel #(
    parameter int RELAY_SETTLE_NS = 1000, // Relay contact settling time
    parameter int MEM_DEPTH = 16 // Setups in setup memory
) (
    input wire logic sys_clk, // 25 MHz clock
    input wire logic resetn, // Synchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB write
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic key_local_dio, // Local / port view key
    input wire logic key_reset, // Reset key
    input wire logic key_open, // Open relays key
    input wire logic key_copy, // Copy key
    input wire logic pen_hit, // Pen click pulse
    input wire logic [2:0] pen_unit, // Unit the pen points at
    input wire logic [2:0] pen_row, // Pen row 0..7
    input wire logic [3:0] pen_col, // Pen column 0..11
    input wire logic [2:0] chain_pos, // This unit's chain position
    input wire logic outside_advance_in, // Outside trigger input
    input wire logic [15:0] port_in, // Digital inputs
    input wire logic [3:0] addr_tens, // Address switch, tens
    input wire logic [3:0] addr_ones, // Address switch, ones
    output logic [15:0] port_out, // Digital outputs
    output logic [95:0] relay_drive, // Relay coils
    output logic [95:0] lamp_matrix, // LED matrix
    output logic port_view_mode, // Port view shown
    output logic copy_lamp, // Copy lamp
    output logic error_lamp, // Error lamp
    output logic spoll_err, // Error flag of poll byte
    output logic talk_lamp, // Talk lamp
    output logic receiver_lamp, // Listen lamp
    output logic bus_control_lamp, // Remote lamp
    output logic matrix_ready_out, // Settling-ready output
    output logic master_role, // Unit is master
    output logic [4:0] bus_addr // Decoded bus address
);
    localparam int STEP_W = $clog2(MEM_DEPTH);
    localparam int RELAY_CYC_RAW = (RELAY_SETTLE_NS + smpc_pkg::CLK_NS - 1) / smpc_pkg::CLK_NS;
    localparam logic [16:0] RELAY_CYC = 17'(RELAY_CYC_RAW < 1 ? 1 : RELAY_CYC_RAW);

    if (MEM_DEPTH < 2 || MEM_DEPTH > 256 || RELAY_CYC_RAW > 65535) begin : g_bad
        $error("smpc_panel: unsupported parameter");
    end

    function automatic int xp_idx(input logic [2:0] row, input logic [3:0] col);
        xp_idx = int'(row) * smpc_pkg::COLS + int'(col);
    endfunction : xp_idx

    // ****************************************
    // State
    // ****************************************
    logic [31:0] prdata_ff, rd_data;
    logic pready_ff, pslverr_ff;
    logic [7:0] ctrl_ff;
    logic copy_ff, remote_ff, load_ff, ready_ff, rdy_out_ff;
    logic err_lamp_ff, spoll_ff, master_ff;
    logic [4:0] bus_addr_ff;
    logic [6:0] addr_val_ff;
    logic [15:0] dout_ff, err_ff, settle_ff;
    logic [16:0] settle_cnt_ff;
    logic [95:0] display_ff, relay_ff, lamp_ff, nxt_display, nxt_relay, port_map, mem_rdata;
    logic [STEP_W-1:0] relay_step_ff, mem_step_ff, rd_step;
    logic [3:0] key_prev_ff;
    logic trig_prev_ff;
    smpc_pkg::smpc_view_t view_ff;

    // ****************************************
    // APB slave
    // ****************************************
    wire apb_setup = psel & ~penable;
    wire apb_do = psel & penable & pready_ff;
    wire wr = apb_do & pwrite;
    wire row_hit = paddr[7:5] == smpc_pkg::DISP_ROWS_HI;
    wire rly_hit = paddr[7:5] == smpc_pkg::RELAY_ROWS_HI;
    wire [2:0] row_sel = paddr[4:2];
    wire wr_ctrl = wr && paddr == smpc_pkg::REG_CTRL;
    wire wr_cmd = wr && paddr == smpc_pkg::REG_CMD;
    wire wr_disp = wr && row_hit;
    wire wr_step = wr && paddr == smpc_pkg::REG_STEP;
    wire addr_ok = row_hit | rly_hit | (paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0);

    always_comb begin
        rd_data = '0;
        case (paddr)
            smpc_pkg::REG_CTRL: rd_data = {24'h0, ctrl_ff[7:1], copy_ff};
            smpc_pkg::REG_STAT: rd_data = {25'h0, addr_val_ff == 7'h0, master_ff, ready_ff,
                remote_ff, view_ff == smpc_pkg::VIEW_PORT, copy_ff, load_ff};
            smpc_pkg::REG_DOUT: rd_data = {16'h0, dout_ff};
            smpc_pkg::REG_DIN: rd_data = {16'h0, port_in};
            smpc_pkg::REG_ERR: rd_data = {16'h0, err_ff};
            smpc_pkg::REG_SETTLE: rd_data = {16'h0, settle_ff};
            smpc_pkg::REG_STEP: rd_data = {16'h0, 8'(mem_step_ff), 8'(relay_step_ff)};
            default: begin
                if (row_hit) begin
                    rd_data = {20'h0, display_ff[int'(row_sel) * smpc_pkg::COLS +: 12]};
                end else if (rly_hit) begin
                    rd_data = {20'h0, relay_ff[int'(row_sel) * smpc_pkg::COLS +: 12]};
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup & ~addr_ok;
            prdata_ff <= apb_setup ? rd_data : '0;
        end
    end

    // ****************************************
    // Panel keys and pen
    // ****************************************
    wire [3:0] keys = {key_copy, key_open, key_reset, key_local_dio};
    wire [3:0] key_edge = keys & ~key_prev_ff;
    wire lockout = ctrl_ff[smpc_pkg::CTRL_LOCKOUT];
    wire panel_ok = ~remote_ff & ~lockout;
    wire do_reset = (panel_ok & key_edge[1]) | (wr_cmd & pwdata[smpc_pkg::CMD_RESET]);
    wire in_xp = view_ff == smpc_pkg::VIEW_XP;
    wire open_xp = in_xp & ((panel_ok & key_edge[2]) | (wr_cmd & pwdata[smpc_pkg::CMD_OPEN]));
    wire pen_me = pen_hit & panel_ok & pen_unit == chain_pos & pen_col < 4'hc;
    wire [6:0] pen_i = 7'(xp_idx(pen_row, pen_col));
    wire pen_out_hi = 32'(pen_col) == smpc_pkg::COL_OUT_HI;
    wire pen_out = pen_out_hi | 32'(pen_col) == smpc_pkg::COL_OUT_LO;
    wire send = wr_cmd & pwdata[smpc_pkg::CMD_SEND];
    wire store = wr_cmd & pwdata[smpc_pkg::CMD_STORE];

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            key_prev_ff <= '0;
            trig_prev_ff <= 1'b0;
        end else begin
            key_prev_ff <= keys;
            trig_prev_ff <= outside_advance_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            view_ff <= smpc_pkg::VIEW_XP;
            remote_ff <= 1'b0;
        end else begin
            if (key_edge[0] & remote_ff & ~lockout) begin
                remote_ff <= 1'b0;
            end else if (wr_cmd & pwdata[smpc_pkg::CMD_REMOTE]) begin
                remote_ff <= 1'b1;
            end
            if (do_reset) begin
                view_ff <= smpc_pkg::VIEW_XP;
            end else if (key_edge[0] & panel_ok) begin
                case (view_ff)
                    smpc_pkg::VIEW_XP: view_ff <= smpc_pkg::VIEW_PORT;
                    smpc_pkg::VIEW_PORT: view_ff <= smpc_pkg::VIEW_XP;
                    default: view_ff <= smpc_pkg::VIEW_XP;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl_ff <= smpc_pkg::CTRL_RST;
            copy_ff <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= pwdata[7:0];
            end
            if (do_reset) begin
                ctrl_ff[smpc_pkg::CTRL_TRIG_EN] <= 1'b0;
                copy_ff <= 1'b0;
            end else if (key_edge[3] & panel_ok) begin
                copy_ff <= ~copy_ff;
            end else if (wr_ctrl) begin
                copy_ff <= pwdata[smpc_pkg::CTRL_COPY];
            end
        end
    end

    // ****************************************
    // Outside trigger and setup steps
    // ****************************************
    // Plain edge sampling: a pulse of 600 ns spans many clock edges
    wire trig_edge = ctrl_ff[smpc_pkg::CTRL_EDGE_RISE] ? (outside_advance_in & ~trig_prev_ff)
        : (~outside_advance_in & trig_prev_ff);
    wire trig_acc = trig_edge & ctrl_ff[smpc_pkg::CTRL_TRIG_EN]
        & ctrl_ff[smpc_pkg::CTRL_EXT_SRC];

    assign rd_step = relay_step_ff + STEP_W'(1);

    always_ff @(posedge sys_clk) begin
        if (!resetn || do_reset) begin
            relay_step_ff <= '0;
            mem_step_ff <= STEP_W'(1);
            load_ff <= 1'b0;
        end else begin
            load_ff <= trig_acc;
            if (wr_step) begin
                relay_step_ff <= pwdata[STEP_W-1:0];
                mem_step_ff <= pwdata[8 +: STEP_W];
            end else begin
                if (trig_acc) begin
                    relay_step_ff <= rd_step;
                end
                if (store) begin
                    mem_step_ff <= mem_step_ff + STEP_W'(1);
                end
            end
        end
    end

    smpc_mem #(.WIDTH(smpc_pkg::XP_W), .DEPTH(MEM_DEPTH)) u_mem (
        .sys_clk(sys_clk),
        .we(store),
        .waddr(mem_step_ff),
        .wdata(display_ff),
        .raddr(rd_step),
        .rdata_ff(mem_rdata)
    );

    // ****************************************
    // Crosspoint display and relays
    // ****************************************
    always_comb begin
        nxt_display = display_ff;
        if (load_ff) begin
            nxt_display = mem_rdata;
        end
        if (wr_disp) begin
            nxt_display[int'(row_sel) * smpc_pkg::COLS +: 12] = pwdata[11:0];
        end
        if (pen_me & in_xp) begin
            nxt_display[pen_i] = ~display_ff[pen_i];
        end
        if (open_xp | do_reset) begin
            nxt_display = '0;
        end
    end

    always_comb begin
        nxt_relay = relay_ff;
        if (load_ff) begin
            nxt_relay = mem_rdata;
        end
        if (send) begin
            nxt_relay = display_ff;
        end
        if (copy_ff) begin
            nxt_relay = nxt_display;
        end
        if (do_reset) begin
            nxt_relay = '0;
        end
    end

    wire relay_chg = nxt_relay != relay_ff;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            display_ff <= '0;
            relay_ff <= '0;
        end else begin
            display_ff <= nxt_display;
            relay_ff <= nxt_relay;
        end
    end

    // ****************************************
    // Settling and ready output
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            settle_cnt_ff <= '0;
            ready_ff <= 1'b1;
            rdy_out_ff <= 1'b1;
        end else begin
            if (relay_chg) begin
                settle_cnt_ff <= RELAY_CYC + {1'b0, settle_ff};
                ready_ff <= 1'b0;
            end else if (settle_cnt_ff != '0) begin
                settle_cnt_ff <= settle_cnt_ff - 17'h1;
                ready_ff <= settle_cnt_ff == 17'h1;
            end
            rdy_out_ff <= ready_ff ~^ ctrl_ff[smpc_pkg::CTRL_RDY_HIGH];
        end
    end

    // ****************************************
    // Digital outputs, errors, settle register
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            dout_ff <= '0;
            settle_ff <= '0;
            err_ff <= '0;
        end else begin
            if (wr && paddr == smpc_pkg::REG_DOUT) begin
                dout_ff <= pwdata[15:0];
            end else if (pen_me & ~in_xp & pen_out) begin
                dout_ff[{pen_out_hi, pen_row}] <= ~dout_ff[{pen_out_hi, pen_row}];
            end
            if (wr && paddr == smpc_pkg::REG_SETTLE) begin
                settle_ff <= pwdata[15:0];
            end
            err_ff <= (err_ff & ~((wr && paddr == smpc_pkg::REG_ERR) ? pwdata[15:0] : 16'h0))
                | {15'h0, trig_acc & ~ready_ff};
        end
    end

    // ****************************************
    // Lamps and address switches
    // ****************************************
    always_comb begin
        port_map = '0;
        for (int r = 0; r < smpc_pkg::ROWS; r++) begin
            port_map[r * smpc_pkg::COLS + smpc_pkg::COL_IN_LO] = port_in[r];
            port_map[r * smpc_pkg::COLS + smpc_pkg::COL_IN_HI] = port_in[r + 8];
            port_map[r * smpc_pkg::COLS + smpc_pkg::COL_OUT_LO] = dout_ff[r];
            port_map[r * smpc_pkg::COLS + smpc_pkg::COL_OUT_HI] = dout_ff[r + 8];
        end
    end

    wire [6:0] sw_val = 7'(addr_tens) * 7'h0a + 7'(addr_ones);

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            lamp_ff <= '0;
            err_lamp_ff <= 1'b0;
            spoll_ff <= 1'b0;
            addr_val_ff <= smpc_pkg::FACTORY_ADDR;
            master_ff <= 1'b0;
            bus_addr_ff <= smpc_pkg::FACTORY_ADDR[4:0];
        end else begin
            lamp_ff <= in_xp ? display_ff : port_map;
            err_lamp_ff <= |err_ff;
            spoll_ff <= |err_ff;
            addr_val_ff <= sw_val;
            master_ff <= addr_val_ff >= smpc_pkg::MASTER_MIN
                && addr_val_ff <= smpc_pkg::MASTER_MAX;
            bus_addr_ff <= addr_val_ff <= smpc_pkg::SLAVE_MAX ? addr_val_ff[4:0]
                : 5'(addr_val_ff - smpc_pkg::MASTER_BIAS);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign port_out = dout_ff;
    assign relay_drive = relay_ff;
    assign lamp_matrix = lamp_ff;
    assign port_view_mode = view_ff == smpc_pkg::VIEW_PORT;
    assign copy_lamp = copy_ff;
    assign error_lamp = err_lamp_ff;
    assign spoll_err = spoll_ff;
    assign talk_lamp = ctrl_ff[smpc_pkg::CTRL_TALK];
    assign receiver_lamp = ctrl_ff[smpc_pkg::CTRL_LISTEN];
    assign bus_control_lamp = remote_ff;
    assign matrix_ready_out = rdy_out_ff;
    assign master_role = master_ff;
    assign bus_addr = bus_addr_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_copy;
        copy_ff && !do_reset |=> relay_ff == display_ff;
    endproperty
    a_copy: assert property (p_copy) else $error("copy did not reach relays");
    property p_copy_key;
        key_edge[3] && panel_ok && !do_reset |=> copy_ff != $past(copy_ff);
    endproperty
    a_copy_key: assert property (p_copy_key) else $error("copy key no toggle");
    property p_view_start;
        $rose(resetn) |-> view_ff == smpc_pkg::VIEW_XP;
    endproperty
    a_view_start: assert property (p_view_start) else $error("wrong start view");
    property p_lamp_xp;
        in_xp ##1 in_xp |-> lamp_ff == $past(display_ff);
    endproperty
    a_lamp_xp: assert property (p_lamp_xp) else $error("xp lamps wrong");
    property p_lamp_port;
        !in_xp |=> lamp_ff[0] == $past(port_in[0]) && lamp_ff[1] == $past(port_in[8])
            && lamp_ff[11] == $past(dout_ff[8]);
    endproperty
    a_lamp_port: assert property (p_lamp_port) else $error("port lamps wrong");
    property p_hold;
        !copy_ff && !send && !load_ff && !do_reset |=> $stable(relay_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("relays moved");
    property p_reset_key;
        do_reset |=> relay_ff == '0 && relay_step_ff == '0 && mem_step_ff == STEP_W'(1)
            && !ctrl_ff[smpc_pkg::CTRL_TRIG_EN];
    endproperty
    a_reset_key: assert property (p_reset_key) else $error("reset key incomplete");
    property p_lockout;
        lockout && !wr_cmd && !wr_ctrl |=> $stable(view_ff) && $stable(copy_ff);
    endproperty
    a_lockout: assert property (p_lockout) else $error("panel acted in lockout");
    property p_trig;
        trig_acc && !wr_step |=> relay_step_ff == $past(rd_step) ##1 display_ff == $past(mem_rdata);
    endproperty
    a_trig: assert property (p_trig) else $error("trigger did not advance");
    property p_ready;
        relay_chg |=> !ready_ff ##1 !rdy_out_ff == ctrl_ff[smpc_pkg::CTRL_RDY_HIGH];
    endproperty
    a_ready: assert property (p_ready) else $error("ready not dropped");
    property p_err;
        err_ff != '0 |=> error_lamp && spoll_err;
    endproperty
    a_err: assert property (p_err) else $error("error lamp dark");
    property p_master;
        addr_val_ff >= smpc_pkg::MASTER_MIN && addr_val_ff <= smpc_pkg::MASTER_MAX |=> master_ff;
    endproperty
    a_master: assert property (p_master) else $error("master not decoded");
    c_trig: cover property (trig_acc ##2 !ready_ff);
    c_pen_out: cover property (pen_me && !in_xp && pen_out);
    c_local: cover property (remote_ff && key_edge[0] ##1 !remote_ff);
endmodule : smpc_panel

// ### tb/smpc_trig_src.sv
`timescale 1ns/100ps
module smpc_trig_src #(
    parameter int HOLD_CYC = 20 // Pulse width in cycles, above 600 ns
) (
    input wire logic sys_clk, // Clock
    output logic pulse // Outside trigger line
);
    initial pulse = 1'b0;
    // Rising pulse held well past the minimum width
    task automatic fire;
        @(posedge sys_clk);
        pulse <= 1'b1;
        repeat (HOLD_CYC) @(posedge sys_clk);
        pulse <= 1'b0;
    endtask : fire
endmodule : smpc_trig_src

// ### tb/switch_matrix_panel_control_tb.sv
`timescale 1ns/100ps
module switch_matrix_panel_control_tb;
    // ****************************************
    // Bench signals and tasks
    // ****************************************
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic pen_hit = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, view, copy_lamp, rdy, master, trig;
    logic pslverr, err_lamp, spoll, talk, rcv, bus_ctl;
    logic [3:0] keys = 4'h0;
    logic [2:0] pen_unit = 3'h0;
    logic [2:0] pen_row = 3'h0;
    logic [3:0] pen_col = 4'h0;
    logic [15:0] port_in = 16'h0;
    logic [15:0] port_out, po;
    logic [15:0] rnd = 16'h76a7;
    logic [3:0] a_t = 4'h1;
    logic [3:0] a_o = 4'h8;
    logic [95:0] relay_drive, lamp_matrix;
    logic [4:0] bus_addr;
    logic [31:0] expq[$];
    int n_fail = 0;
    int check_count = 0;
    int vals[3] = '{30, 31, 60};

    always #20 sys_clk = ~sys_clk;

    smpc_panel u_dut (.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .key_local_dio(keys[0]), .key_reset(keys[2]), .key_open(keys[1]),
        .key_copy(keys[3]), .pen_hit, .pen_unit, .pen_row, .pen_col, .chain_pos(3'h0),
        .outside_advance_in(trig), .port_in, .addr_tens(a_t), .addr_ones(a_o), .port_out,
        .relay_drive, .lamp_matrix, .port_view_mode(view), .copy_lamp, .error_lamp(err_lamp),
        .spoll_err(spoll), .talk_lamp(talk), .receiver_lamp(rcv), .bus_control_lamp(bus_ctl),
        .matrix_ready_out(rdy), .master_role(master), .bus_addr);
    smpc_trig_src u_src (.sys_clk, .pulse(trig));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
        check_count++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask : wt

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd

    task automatic key(input logic [3:0] m);
        @(posedge sys_clk);
        keys <= m;
        @(posedge sys_clk);
        keys <= 4'h0;
        wt(3);
    endtask : key

    task automatic pen(input logic [2:0] u, input logic [2:0] r, input logic [3:0] c);
        @(posedge sys_clk);
        pen_hit <= 1'b1;
        pen_unit <= u;
        pen_row <= r;
        pen_col <= c;
        @(posedge sys_clk);
        pen_hit <= 1'b0;
        wt(3);
    endtask : pen

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Read data is compared when the access cycle shows it
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) begin
            chk("prdata", expq.pop_front(), prdata);
            chk("pslverr", {95'h0, paddr == 8'h20}, {95'h0, pslverr});
        end
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        wt(3);
        chk("bus_addr", 96'd18, bus_addr);
        chk("view", 96'd0, view);
        rnd = lfsr(rnd);
        apb(1'b1, 8'h40, {20'h0, rnd[11:0]});
        rd(8'h60, 32'h0);
        apb(1'b1, 8'h08, 32'h1);
        wt(1);
        chk("ready", 96'd0, rdy);
        rd(8'h60, {20'h0, rnd[11:0]});
        wt(40);
        chk("ready", 96'd1, rdy);
        $display("test edit and send done");
        key(4'h8);
        chk("copy_lamp", 96'd1, copy_lamp);
        rnd = lfsr(rnd);
        apb(1'b1, 8'h44, {20'h0, rnd[11:0]});
        rd(8'h64, {20'h0, rnd[11:0]});
        wt(0);
        chk("lamp row", {84'h0, rnd[11:0]}, {84'h0, lamp_matrix[23:12]});
        key(4'h2);
        chk("lamps", 96'h0, lamp_matrix);
        chk("relays", 96'h0, relay_drive);
        $display("test copy and open done");
        wt(40);
        apb(1'b1, 8'h00, 32'h1e);
        rnd = lfsr(rnd);
        apb(1'b1, 8'h48, {20'h0, rnd[11:0]});
        apb(1'b1, 8'h08, 32'h3);
        u_src.fire();
        wt(5);
        chk("err lamp", 96'd1, err_lamp);
        chk("poll flag", 96'd1, spoll);
        rd(8'h1c, 32'h0201);
        rd(8'h68, {20'h0, rnd[11:0]});
        key(4'h4);
        chk("relays", 96'h0, relay_drive);
        rd(8'h1c, 32'h0100);
        rd(8'h20, 32'h0);
        $display("test trigger and reset done");
        rnd = lfsr(rnd);
        port_in <= rnd;
        key(4'h1);
        chk("view", 96'd1, view);
        for (int r = 0; r < 8; r++) begin
            chk("in lo", {95'h0, port_in[r]}, {95'h0, lamp_matrix[r*12]});
            chk("in hi", {95'h0, port_in[r+8]}, {95'h0, lamp_matrix[r*12+1]});
        end
        po = port_out;
        pen(3'h0, 3'h2, 4'ha);
        chk("out", {95'h0, ~po[2]}, {95'h0, port_out[2]});
        chk("out lamp", {95'h0, ~po[2]}, {95'h0, lamp_matrix[34]});
        pen(3'h1, 3'h3, 4'hb);
        chk("other unit", {95'h0, po[11]}, {95'h0, port_out[11]});
        key(4'h1);
        chk("view", 96'd0, view);
        apb(1'b1, 8'h08, 32'h10);
        key(4'h8);
        chk("remote", 96'd1, bus_ctl);
        chk("copy_lamp", 96'd0, copy_lamp);
        key(4'h1);
        chk("remote", 96'd0, bus_ctl);
        chk("view", 96'd0, view);
        apb(1'b1, 8'h00, 32'hf9);
        key(4'h8);
        chk("copy_lamp", 96'd1, copy_lamp);
        chk("talk", 96'd1, talk);
        chk("listen", 96'd1, rcv);
        $display("test port view and lockout done");
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            a_t <= 4'(vals[i] / 10);
            a_o <= 4'(vals[i] % 10);
            wt(4);
            chk("master", {95'h0, vals[i] > 30}, {95'h0, master});
            chk("addr", 96'(vals[i] > 30 ? vals[i] - 30 : vals[i]), bus_addr);
        end
        $display("test address switches done");
        tally_and_finish();
    end
endmodule : switch_matrix_panel_control_tb
